/* verilog/ffa_pkg.sv */
`default_nettype none

package ffa_pkg;

  // ------------------------------------------------------------
  // Widths of the arithmetic formats.
  // ------------------------------------------------------------
  localparam int MANT_W   = 16;  // Adder mantissa and accumulator mantissa.
  localparam int EXP_W    = 4;   // Exponent field of every float value.
  localparam int MUL_IN_W = 12;  // Multiplier input mantissa width.
  localparam int ACC_W    = MANT_W + EXP_W;
  localparam int XEXP_W   = 7;   // Widened exponent used before clamping.

  // ------------------------------------------------------------
  // Limits and saturation values.
  // ------------------------------------------------------------
  localparam logic signed [6:0]  EXP_MAX  = 7'sd7;
  localparam logic signed [6:0]  EXP_MIN  = -7'sd8;
  localparam logic [3:0]         EXP_MAXF = 4'h7;
  localparam logic [3:0]         EXP_MINF = 4'h8;
  localparam logic [15:0]        MANT_POS = 16'h7fff;
  localparam logic [15:0]        MANT_NEG = 16'h8000;

  // ------------------------------------------------------------
  // Field positions inside an accumulator word.
  // ------------------------------------------------------------
  localparam int ACC_MANT_LSB = 4;
  localparam int ACC_EXP_LSB  = 0;

  // Product bits kept from the 24-bit signed multiplier output.
  localparam int PROD_TOP = 22;
  localparam int PROD_BOT = 7;

  // ------------------------------------------------------------
  // Reset values.
  // ------------------------------------------------------------
  localparam logic [19:0] ACC_RST = 20'h00000;

  // ------------------------------------------------------------
  // Operations selected by instruction decode.
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_MUL_FIX = 3'h0,  // Fixed multiply.
    OP_MUL_FLT = 3'h1,  // Float multiply.
    OP_ADD_FIX = 3'h2,  // Fixed add or subtract.
    OP_ADD_FLT = 3'h3,  // Float add or subtract.
    OP_FIX2FLT = 3'h4,  // Fixed to float conversion.
    OP_FLT2FIX = 3'h5   // Float to fixed conversion.
  } ffa_op_t;

endpackage : ffa_pkg

`default_nettype wire

/* verilog/ffa_float_fixed_unit.sv */
// How it works
// - Fixed multiply: signed 12x12 bits to 16 bits.
// - Float multiply: signed mantissas, 4-bit exponents.
// - Multiplier input mantissa spans -1 to 1-2^-11.
// - Multiplier output mantissa spans -1 to 1-2^-15.
// - Exponent is signed, -8 through 7.
// - Align shifter, 16-bit ALU, then normalising shifter.
// - In-range exponent: normalised result written unchanged.
// - Exponent overflow: clamp to 7, maximal mantissa.
// - Protect bit saturates fixed add overflow.
// - Underflow: exponent -8, mantissa shifted by -8-C.
// - Both exponents -8: behaves as fixed add.
// - Alignment truncates; normalisation fills zeros.
// - Subtract adds complement; aligned term skips +1.
// - Conversions take one instruction, scale from memory.
// - Fixed to float: value times 2^n, normalised.
// - Float to fixed: shift by l-m or m-l.
// - Float to fixed overflow saturates by sign.
// - Float: 16-bit mantissa, point below sign, 4-bit exponent.
// - Two 20-bit accumulators, instruction selects one.
`timescale 1ns/1ps
`default_nettype none

module ffa_float_fixed_unit (
  input  wire logic            clk,                    // Instruction clock.
  input  wire logic            rst_n,                  // Synchronous reset, active low.
  input  wire logic            opValid,                // One operation this cycle.
  input  wire ffa_pkg::ffa_op_t opCode,                // Operation select.
  input  wire logic            subtract,               // Add/sub ops: x minus y.
  input  wire logic            accSel,                 // 0 writes accumulator A, 1 writes B.
  input  wire logic            overflowProtectEnable,  // Fixed add saturation enable.
  input  wire logic [15:0]     xMant,                  // X operand mantissa or fixed value.
  input  wire logic [3:0]      xExp,                   // X operand exponent.
  input  wire logic [15:0]     yMant,                  // Y operand mantissa or fixed value.
  input  wire logic [3:0]      yExp,                   // Y operand exponent.
  input  wire logic [3:0]      scale,                  // Scale factor read from data memory.
  output logic [19:0]          accA,                   // Accumulator A.
  output logic [19:0]          accB,                   // Accumulator B.
  output logic [19:0]          mulOut,                 // Multiplier output register.
  output logic [19:0]          result,                 // Last value written by any op.
  output logic                 resValid,               // Pulse: result updated.
  output logic                 expOverflow,            // Pulse flag: exponent clamped high.
  output logic                 expUnderflow,           // Pulse flag: exponent forced to -8.
  output logic                 fixOverflow             // Pulse flag: fixed result overflowed, saturated or wrapped.
);
  import ffa_pkg::*;

  // ------------------------------------------------------------
  // Normalise and clamp helper.
  // ------------------------------------------------------------
  // Takes a 17-bit signed sum and a widened exponent, returns
  // {overflow, underflow, mantissa, exponent}.
  function automatic logic [21:0] normPack(input logic signed [16:0] m,
                                           input logic signed [6:0]  e);
    logic signed [15:0] mt;
    logic signed [6:0]  et;
    logic signed [6:0]  lz;
    logic               done;
    logic               ov;
    logic               un;
    mt   = m[15:0];
    et   = e;
    lz   = 7'sd0;
    done = 1'b0;
    ov   = 1'b0;
    un   = 1'b0;
    if (m[16] != m[15]) begin
      // Carry out of the 16-bit ALU: shift right once.
      mt = m[16:1];
      et = e + 7'sd1;
    end else begin
      // Count redundant sign bits below the sign.
      for (int i = 14; i >= 0; i--) begin
        if (!done && (m[i] == m[15])) begin
          lz = lz + 7'sd1;
        end else begin
          done = 1'b1;
        end
      end
      if (e - lz >= EXP_MIN) begin
        mt = m[15:0] <<< lz;
        et = e - lz;
      end else if (e >= EXP_MIN) begin
        // Partial normalisation stops at the lowest exponent.
        mt = m[15:0] <<< (e - EXP_MIN);
        et = EXP_MIN;
      end else begin
        // Exponent already below range: move right by -8-C.
        mt = $signed(m[15:0]) >>> (EXP_MIN - e);
        et = EXP_MIN;
        un = 1'b1;
      end
    end
    if (et > EXP_MAX) begin
      mt = mt[15] ? MANT_NEG : MANT_POS;
      et = EXP_MAX;
      ov = 1'b1;
    end
    normPack = {ov, un, mt, et[3:0]};
  endfunction : normPack

  // Widens a 4-bit exponent field to the working width.
  function automatic logic signed [6:0] wideExp(input logic [3:0] f);
    wideExp = {{3{f[3]}}, f};
  endfunction : wideExp

  // ------------------------------------------------------------
  // Multiplier.
  // ------------------------------------------------------------
  logic signed [11:0] mulX;     // X mantissa, top 12 bits.
  logic signed [11:0] mulY;     // Y mantissa, top 12 bits.
  logic signed [23:0] prod;     // Full signed product.
  logic        [15:0] prodTop;  // Product rounded down to 16 bits.
  logic        [21:0] mulNorm;  // Float multiply after clamping.
  logic        [19:0] next_mulOut;

  always_comb begin
    mulX    = xMant[15:4];
    mulY    = yMant[15:4];
    prod    = mulX * mulY;
    // Minus one squared cannot be held, so it becomes the top value.
    if (mulX == 12'sh800 && mulY == 12'sh800) begin
      prodTop = MANT_POS;
    end else begin
      prodTop = prod[PROD_TOP:PROD_BOT];
    end
    mulNorm = normPack({prodTop[15], prodTop},
                       wideExp(xExp) + wideExp(yExp));
    if (opCode == OP_MUL_FLT) begin
      next_mulOut = mulNorm[19:0];
    end else begin
      next_mulOut = {prodTop, 4'h0};
    end
  end

  // ------------------------------------------------------------
  // Floating adder unit: align, add, normalise.
  // ------------------------------------------------------------
  logic signed [6:0]  ex;       // X exponent, widened.
  logic signed [6:0]  ey;       // Y exponent, widened.
  logic               xBig;     // X carries the larger exponent.
  logic signed [16:0] opX;      // Aligned X term.
  logic signed [16:0] opY;      // Aligned Y term, complemented on subtract.
  logic signed [16:0] fSum;     // ALU sum.
  logic        [21:0] fNorm;    // Normalised float sum.

  always_comb begin
    ex   = wideExp(xExp);
    ey   = wideExp(yExp);
    xBig = ex > ey;
    opX  = {xMant[15], xMant};
    opY  = subtract ? {~yMant[15], ~yMant} : {yMant[15], yMant};
    if (xBig) begin
      // Low bits of the smaller operand fall off the end.
      opY = opY >>> (ex - ey);
    end else begin
      opX = opX >>> (ey - ex);
      if (subtract) begin
        opY = opY + 17'sd1;
      end
    end
    fSum  = opX + opY;
    fNorm = normPack(fSum, xBig ? ex : ey);
  end

  // ------------------------------------------------------------
  // Fixed adder with optional saturation.
  // ------------------------------------------------------------
  logic signed [16:0] xSum;     // Fixed sum with guard bit.
  logic               xOvf;     // Fixed sum left the 16-bit range.
  logic        [15:0] xRes;     // Fixed result after protection.

  always_comb begin
    if (subtract) begin
      xSum = {xMant[15], xMant} - {yMant[15], yMant};
    end else begin
      xSum = {xMant[15], xMant} + {yMant[15], yMant};
    end
    xOvf = xSum[16] != xSum[15];
    if (xOvf && overflowProtectEnable) begin
      xRes = xSum[16] ? MANT_NEG : MANT_POS;
    end else begin
      xRes = xSum[15:0];
    end
  end

  // ------------------------------------------------------------
  // Format conversions.
  // ------------------------------------------------------------
  logic        [21:0] cFlt;     // Fixed to float result.
  logic signed [6:0]  sl;       // Target scale, widened.
  logic signed [6:0]  dExp;     // Target scale minus source exponent.
  logic signed [31:0] cWide;    // Left-shifted mantissa before range check.
  logic        [15:0] cFix;     // Float to fixed result.
  logic               cOvf;     // Float to fixed saturated.

  always_comb begin
    // Value times 2^n, normalised into mantissa and exponent.
    cFlt  = normPack({xMant[15], xMant}, wideExp(scale));
    sl    = wideExp(scale);
    dExp  = sl - ex;
    cWide = {{16{xMant[15]}}, xMant};
    cOvf  = 1'b0;
    if (dExp >= 7'sd0) begin
      cFix = $signed(xMant) >>> dExp;
    end else begin
      cWide = cWide <<< (-dExp);
      cFix  = cWide[15:0];
      if (cWide[31:15] != {17{cWide[31]}}) begin
        cFix = xMant[15] ? MANT_NEG : MANT_POS;
        cOvf = 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Result select for the accumulator write.
  // ------------------------------------------------------------
  logic        writesAcc;       // Operation targets an accumulator.
  logic [19:0] next_result;
  logic        next_eOvf;
  logic        next_eUnf;
  logic        next_fOvf;

  always_comb begin
    writesAcc   = 1'b1;
    next_result = result;
    next_eOvf   = 1'b0;
    next_eUnf   = 1'b0;
    next_fOvf   = 1'b0;
    case (opCode)
      OP_ADD_FLT: begin
        next_result = fNorm[19:0];
        next_eOvf   = fNorm[21];
        next_eUnf   = fNorm[20];
      end
      OP_ADD_FIX: begin
        next_result = {xRes, 4'h0};
        next_fOvf   = xOvf;
      end
      OP_FIX2FLT: begin
        next_result = cFlt[19:0];
        next_eOvf   = cFlt[21];
        next_eUnf   = cFlt[20];
      end
      OP_FLT2FIX: begin
        next_result = {cFix, scale};
        next_fOvf   = cOvf;
      end
      OP_MUL_FLT: begin
        writesAcc   = 1'b0;
        next_result = next_mulOut;
        next_eOvf   = mulNorm[21];
        next_eUnf   = mulNorm[20];
      end
      default: begin
        writesAcc   = 1'b0;
        next_result = next_mulOut;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Accumulators and multiplier output register.
  // ------------------------------------------------------------
  // The selected accumulator takes the result in the same edge.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      accA <= ACC_RST;
      accB <= ACC_RST;
    end else if (opValid && writesAcc) begin
      if (accSel) begin
        accB <= next_result;
      end else begin
        accA <= next_result;
      end
    end
  end

  // The multiplier output register holds one product per operation.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mulOut <= ACC_RST;
    end else if (opValid && (opCode == OP_MUL_FIX || opCode == OP_MUL_FLT)) begin
      mulOut <= next_mulOut;
    end
  end

  // ------------------------------------------------------------
  // Result mirror and status pulses.
  // ------------------------------------------------------------
  // Flags live for one cycle alongside resValid.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      result       <= ACC_RST;
      resValid     <= 1'b0;
      expOverflow  <= 1'b0;
      expUnderflow <= 1'b0;
      fixOverflow  <= 1'b0;
    end else begin
      resValid     <= opValid;
      expOverflow  <= opValid & next_eOvf;
      expUnderflow <= opValid & next_eUnf;
      fixOverflow  <= opValid & next_fOvf;
      if (opValid) begin
        result <= next_result;
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions and cover points.
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  resultOneCycle_a: assert property (
    opValid |=> resValid ##1 !resValid || $past(opValid))
    else $error("Result pulse did not follow the operation.");
  expClampHigh_a: assert property (
    expOverflow |-> result[3:0] == EXP_MAXF &&
      (result[19:4] == MANT_POS || result[19:4] == MANT_NEG))
    else $error("Exponent overflow without full clamp.");
  expClampLow_a: assert property (
    expUnderflow |-> result[3:0] == EXP_MINF)
    else $error("Exponent underflow did not force minus eight.");
  fixSaturate_a: assert property (
    opValid && opCode == OP_ADD_FIX && overflowProtectEnable ##1 fixOverflow
      |-> result[19:4] == MANT_POS || result[19:4] == MANT_NEG)
    else $error("Protected fixed overflow did not saturate.");
  fixWrap_a: assert property (
    opValid && opCode == OP_ADD_FIX && !overflowProtectEnable ##1 fixOverflow
      |-> result[19:4] == $past(xSum[15:0]))
    else $error("Unprotected fixed overflow did not wrap.");
  mulZeroY_a: assert property (
    opValid && opCode == OP_MUL_FIX && yMant[15:4] == 12'h000
      |=> mulOut == 20'h00000)
    else $error("Zero multiplier input gave a nonzero product.");
  bothMinExp_a: assert property (
    opValid && opCode == OP_ADD_FLT && xExp == EXP_MINF && yExp == EXP_MINF
      |=> expOverflow || result[3:0] == EXP_MINF || result[3:0] == 4'h9)
    else $error("Minimum exponent add left the fixed range.");
  toFixSat_a: assert property (
    opValid && opCode == OP_FLT2FIX ##1 fixOverflow
      |-> result[19:4] == ($past(xMant[15]) ? MANT_NEG : MANT_POS))
    else $error("Conversion overflow saturated to the wrong sign.");
  accPick_a: assert property (
    opValid && opCode == OP_ADD_FLT && accSel |=> accB == result)
    else $error("Accumulator B missed the float sum.");

  toFloatNorm_a: assert property (
    opValid && opCode == OP_FIX2FLT && xMant != 16'h0000 ##1 !expUnderflow
      |-> result[19] != result[18] || result[3:0] == EXP_MINF)
    else $error("Converted value left unnormalised.");

  floatOvfSeen_c: cover property (
    opValid && opCode == OP_ADD_FLT ##1 expOverflow);
  floatUnfSeen_c: cover property (
    opValid && opCode == OP_MUL_FLT ##1 expUnderflow);
  convSatSeen_c: cover property (
    opValid && opCode == OP_FLT2FIX ##1 fixOverflow);
  subBackToBack_c: cover property (
    opValid && subtract ##1 opValid && subtract);

endmodule : ffa_float_fixed_unit

`default_nettype wire

/* sim/test_ffa_float_fixed_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module test_ffa_float_fixed_unit;
  import ffa_pkg::*;

  // ------------------------------------------------------------
  // Stimulus and observed signals.
  // ------------------------------------------------------------
  logic        clk;                    // Instruction clock, 5 ns period.
  logic        rst_n;                  // Synchronous reset, active low.
  logic        opValid;                // One operation this cycle.
  ffa_op_t     opCode;                 // Operation select.
  logic        subtract;               // Subtract for the add operations.
  logic        accSel;                 // Accumulator select.
  logic        overflowProtectEnable;  // Fixed add saturation enable.
  logic [15:0] xMant;                  // X mantissa or fixed value.
  logic [3:0]  xExp;                   // X exponent.
  logic [15:0] yMant;                  // Y mantissa or fixed value.
  logic [3:0]  yExp;                   // Y exponent.
  logic [3:0]  scale;                  // Scale factor.
  logic [19:0] accA;                   // Accumulator A.
  logic [19:0] accB;                   // Accumulator B.
  logic [19:0] mulOut;                 // Multiplier output.
  logic [19:0] result;                 // Last written value.
  logic        resValid;               // Result pulse.
  logic        expOverflow;            // Exponent clamp pulse.
  logic        expUnderflow;           // Exponent underflow pulse.
  logic        fixOverflow;            // Fixed overflow pulse.
  int          failCount;              // Mismatches seen.
  int          samplesChecked;         // Comparisons made.

  ffa_float_fixed_unit i_dut (
    .clk(clk), .rst_n(rst_n), .opValid(opValid), .opCode(opCode), .subtract(subtract),
    .accSel(accSel), .overflowProtectEnable(overflowProtectEnable), .xMant(xMant),
    .xExp(xExp), .yMant(yMant), .yExp(yExp), .scale(scale), .accA(accA), .accB(accB),
    .mulOut(mulOut), .result(result), .resValid(resValid), .expOverflow(expOverflow),
    .expUnderflow(expUnderflow), .fixOverflow(fixOverflow)
  );

  // ------------------------------------------------------------
  // Clock and watchdog.
  // ------------------------------------------------------------
  // The clock toggles every half period.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // The tests need well under a hundred cycles, so 4000 means a hang.
  initial begin
    #20000;
    failCount++;
    close_out();
  end

  // ------------------------------------------------------------
  // Shared tasks.
  // ------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checked %0d mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Compares a 20-bit word.
  task automatic chk20(input string name, input logic [19:0] expV, input logic [19:0] gotV);
    samplesChecked++;
    if (gotV !== expV) begin
      failCount++;
      $display("mismatch %s expected %h seen %h", name, expV, gotV);
    end
  endtask : chk20

  // Compares a one-bit flag.
  task automatic chk1(input string name, input logic expV, input logic gotV);
    samplesChecked++;
    if (gotV !== expV) begin
      failCount++;
      $display("mismatch %s expected %b seen %b", name, expV, gotV);
    end
  endtask : chk1

  // Presents one operation for one edge; outputs are settled on return.
  task automatic do_op(input ffa_op_t op, input logic sub, input logic sel, input logic ope,
                       input logic [15:0] xm, input logic [3:0] xe, input logic [15:0] ym,
                       input logic [3:0] ye, input logic [3:0] sc);
    @(posedge clk);
    #1;
    opValid = 1'b1;
    opCode = op;
    subtract = sub;
    accSel = sel;
    overflowProtectEnable = ope;
    xMant = xm;
    xExp = xe;
    yMant = ym;
    yExp = ye;
    scale = sc;
    @(posedge clk);
    #1;
    opValid = 1'b0;
  endtask : do_op

  // ------------------------------------------------------------
  // Scenarios.
  // ------------------------------------------------------------
  // Accumulators, mulOut and resValid are cleared while reset is held.
  task automatic t_reset();
    chk20("accA", ACC_RST, accA);
    chk20("accB", ACC_RST, accB);
    chk20("mulOut", ACC_RST, mulOut);
    chk1("resValid", 1'b0, resValid);
  endtask : t_reset

  // A half plus a half gives a normalised one half at exponent 1.
  task automatic t_walk();
    do_op(OP_ADD_FLT, 1'b0, 1'b0, 1'b0, 16'h4000, 4'h0, 16'h4000, 4'h0, 4'h0);
    chk20("accA", 20'h40001, accA);
    chk20("result", 20'h40001, result);
    chk1("resValid", 1'b1, resValid);
    @(posedge clk);
    #1;
    chk1("resValid", 1'b0, resValid);
  endtask : t_walk

  // Exponent overflow clamps in both signs, into either accumulator.
  task automatic t_exp_over();
    do_op(OP_ADD_FLT, 1'b0, 1'b1, 1'b0, 16'h4000, 4'h7, 16'h4000, 4'h7, 4'h0);
    chk20("accB", 20'h7fff7, accB);
    chk1("expOverflow", 1'b1, expOverflow);
    do_op(OP_ADD_FLT, 1'b0, 1'b0, 1'b0, 16'h8000, 4'h7, 16'h8000, 4'h7, 4'h0);
    chk20("accA", 20'h80007, accA);
    chk20("accB", 20'h7fff7, accB);
  endtask : t_exp_over

  // Fixed add saturates only with protection on.
  task automatic t_fix_sat();
    do_op(OP_ADD_FIX, 1'b0, 1'b0, 1'b1, 16'h7fff, 4'h0, 16'h0001, 4'h0, 4'h0);
    chk20("accA", 20'h7fff0, accA);
    chk1("fixOverflow", 1'b1, fixOverflow);
    do_op(OP_ADD_FIX, 1'b1, 1'b0, 1'b1, 16'h8000, 4'h0, 16'h0001, 4'h0, 4'h0);
    chk20("accA", 20'h80000, accA);
    do_op(OP_ADD_FIX, 1'b0, 1'b0, 1'b0, 16'h7fff, 4'h0, 16'h0001, 4'h0, 4'h0);
    chk20("accA", 20'h80000, accA);
  endtask : t_fix_sat

  // Both exponents at -8 act as a fixed add and subtract.
  task automatic t_both_min();
    do_op(OP_ADD_FLT, 1'b0, 1'b0, 1'b0, 16'h0001, 4'h8, 16'h0002, 4'h8, 4'h0);
    chk20("accA", 20'h00038, accA);
    do_op(OP_ADD_FLT, 1'b1, 1'b0, 1'b0, 16'h0003, 4'h8, 16'h0001, 4'h8, 4'h0);
    chk20("accA", 20'h00028, accA);
  endtask : t_both_min

  // Larger minuend exponent skips the increment; alignment drops low bits.
  task automatic t_sub_err();
    do_op(OP_ADD_FLT, 1'b1, 1'b0, 1'b0, 16'h4000, 4'h1, 16'h4000, 4'h0, 4'h0);
    chk20("accA", 20'h7ffcf, accA);
    do_op(OP_ADD_FLT, 1'b0, 1'b0, 1'b0, 16'h4000, 4'h2, 16'h0003, 4'h0, 4'h0);
    chk20("accA", 20'h40002, accA);
  endtask : t_sub_err

  // Multiplier in both modes, the minus one corner and underflow.
  task automatic t_mul();
    do_op(OP_MUL_FIX, 1'b0, 1'b0, 1'b0, 16'h4000, 4'h0, 16'hc000, 4'h0, 4'h0);
    chk20("mulOut", 20'he0000, mulOut);
    do_op(OP_MUL_FIX, 1'b0, 1'b0, 1'b0, 16'h8000, 4'h0, 16'h8000, 4'h0, 4'h0);
    chk20("mulOut", 20'h7fff0, mulOut);
    do_op(OP_MUL_FLT, 1'b0, 1'b0, 1'b0, 16'h400f, 4'h2, 16'h4000, 4'h1, 4'h0);
    chk20("mulOut", 20'h40002, mulOut);
    chk20("result", 20'h40002, result);
    do_op(OP_MUL_FLT, 1'b0, 1'b0, 1'b0, 16'h4000, 4'h8, 16'h4000, 4'hf, 4'h0);
    chk20("mulOut", 20'h10008, mulOut);
    chk1("expUnderflow", 1'b1, expUnderflow);
    do_op(OP_MUL_FLT, 1'b0, 1'b0, 1'b0, 16'hc000, 4'h8, 16'h4000, 4'hf, 4'h0);
    chk20("mulOut", 20'hf0008, mulOut);
    do_op(OP_MUL_FIX, 1'b0, 1'b0, 1'b0, 16'h8000, 4'h0, 16'h000f, 4'h0, 4'h0);
    chk20("mulOut", 20'h00000, mulOut);
  endtask : t_mul

  // Conversions in one step each, including saturation by sign.
  task automatic t_conv();
    do_op(OP_FIX2FLT, 1'b0, 1'b0, 1'b0, 16'h0100, 4'h0, 16'h0000, 4'h0, 4'h3);
    chk20("accA", 20'h4000d, accA);
    do_op(OP_FLT2FIX, 1'b0, 1'b1, 1'b0, 16'h4000, 4'h2, 16'h0000, 4'h0, 4'h4);
    chk20("accB", 20'h10004, accB);
    do_op(OP_FLT2FIX, 1'b0, 1'b1, 1'b0, 16'h0400, 4'h3, 16'h0000, 4'h0, 4'h1);
    chk20("accB", 20'h10001, accB);
    do_op(OP_FLT2FIX, 1'b0, 1'b0, 1'b0, 16'hc000, 4'h0, 16'h0000, 4'h0, 4'h2);
    chk20("accA", 20'hf0002, accA);
    do_op(OP_FLT2FIX, 1'b0, 1'b1, 1'b0, 16'h4000, 4'h3, 16'h0000, 4'h0, 4'h0);
    chk20("accB", 20'h7fff0, accB);
    chk1("fixOverflow", 1'b1, fixOverflow);
    do_op(OP_FLT2FIX, 1'b0, 1'b1, 1'b0, 16'hc000, 4'h3, 16'h0000, 4'h0, 4'h0);
    chk20("accB", 20'h80000, accB);
  endtask : t_conv

  // Two subtracts on consecutive edges land in both accumulators.
  task automatic t_burst();
    @(posedge clk);
    #1;
    opValid = 1'b1;
    opCode = OP_ADD_FIX;
    subtract = 1'b1;
    accSel = 1'b0;
    overflowProtectEnable = 1'b0;
    xMant = 16'h0005;
    yMant = 16'h0003;
    @(posedge clk);
    #1;
    accSel = 1'b1;
    xMant = 16'h0009;
    chk20("accA", 20'h00020, accA);
    @(posedge clk);
    #1;
    opValid = 1'b0;
    chk20("accB", 20'h00060, accB);
    chk1("resValid", 1'b1, resValid);
  endtask : t_burst

  // ------------------------------------------------------------
  // Main sequence.
  // ------------------------------------------------------------
  // Resets for ten cycles, then runs every scenario in turn.
  initial begin
    failCount = 0;
    samplesChecked = 0;
    rst_n = 1'b0;
    opValid = 1'b0;
    opCode = OP_MUL_FIX;
    subtract = 1'b0;
    accSel = 1'b0;
    overflowProtectEnable = 1'b0;
    xMant = 16'h0000;
    xExp = 4'h0;
    yMant = 16'h0000;
    yExp = 4'h0;
    scale = 4'h0;
    repeat (10) @(posedge clk);
    #1;
    t_reset();
    rst_n = 1'b1;
    t_walk();
    t_exp_over();
    t_fix_sat();
    t_both_min();
    t_sub_err();
    t_mul();
    t_conv();
    t_burst();
    close_out();
  end

endmodule : test_ffa_float_fixed_unit

`default_nettype wire
